/* File: common/vgc_pkg.sv */
package vgc_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] LINE_OFS   = 8'h04;
    localparam logic [7:0] STAT_OFS   = 8'h08;
    localparam logic [7:0] ACC_OFS    = 8'h0c;
    localparam logic [7:0] DATA_OFS   = 8'h10;
    localparam logic [7:0] COORD_OFS  = 8'h14;

    // Control register fields
    localparam int PC_LOAD_N_BIT = 0;
    localparam int PC_CNT_EN_BIT = 1;
    localparam int ADDR_SEL_BIT  = 2;
    localparam int ACC_SEL_BIT   = 3;
    localparam int RAM_SEL_BIT   = 4;
    localparam int RAM_DLY_BIT   = 5;
    localparam int RAM_NIB_BIT   = 6;
    localparam int DATA_SEL_BIT  = 7;
    localparam int ALU_FN_LSB    = 8;
    localparam int CARRY_IN_BIT  = 12;
    localparam int PRI_MODE_LSB  = 13;
    localparam int SEC_MODE_LSB  = 15;
    localparam int PRESET_LD_BIT = 17;
    localparam int PAGE_LD_BIT   = 18;
    localparam int IR_LD_BIT     = 19;
    localparam int DR_LD_BIT     = 20;
    localparam int MUX_RST_BIT   = 21;
    localparam int MUX_ODD_BIT   = 22;
    localparam int MUX_EVEN_BIT  = 23;
    localparam int DISP_BIT      = 24;
    localparam int COORD_LD_BIT  = 25;
    localparam int IR_NIB_BIT    = 26;
    localparam int ALU_B_BIT     = 27;
    localparam int CTRL_W        = 28;

    // Control reset value: counter load released (active low), all else idle
    localparam logic [CTRL_W-1:0] CTRL_RST = 28'h0000001;

    // Accumulator shift modes
    localparam logic [1:0] ACC_HOLD  = 2'h0;
    localparam logic [1:0] ACC_SHR   = 2'h1;
    localparam logic [1:0] ACC_SHL   = 2'h2;
    localparam logic [1:0] ACC_LOAD  = 2'h3;

    localparam int        WORD_W      = 12;
    localparam int        SLICE_W     = 4;
    localparam logic [11:0] LINE_MAX  = 12'hfff;
    localparam logic [11:0] LINE_RST  = 12'h000;

    // Line timer tick period in system clock cycles
    localparam int        LINE_DIV_DEF = 1;

endpackage

/* File: rtl/vgc_datapath.sv */
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps

module vgc_datapath #(
    parameter int LINE_DIV = vgc_pkg::LINE_DIV_DEF
) (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Program memory banks
    output logic      [10:0] bank_addr,
    output logic             bank_odd,
    input  wire logic [7:0]  even_bank_data,
    input  wire logic [7:0]  odd_bank_data,
    // Working storage RAM
    output logic      [7:0]  ram_address_bits,
    output logic      [7:0]  ram_write_data,
    input  wire logic [7:0]  ram_output_bits,
    // Sequencer
    output logic      [3:0]  instruction_data_lines,
    // Deflection and beam
    output logic      [11:0] x_coord,
    output logic      [11:0] y_coord,
    output logic             beam_on
);

    typedef struct packed {
        logic [vgc_pkg::CTRL_W-1:0] ctrl;
        logic [11:0] line_len;
        logic [11:0] line_cnt;
        logic        line_run;
        logic        line_zeroed;
        logic [15:0] div_cnt;
        logic [11:0] pc;
        logic [11:0] preset;
        logic [7:0]  mem_dly;
        logic [7:0]  ir;
        logic [7:0]  dr;
        logic [7:0]  dr_dly;
        logic [3:0]  page;
        logic [11:0] pri;
        logic [11:0] sec;
        logic        carry_out;
        logic [10:0] bank_addr;
        logic        bank_odd;
        logic [7:0]  ram_addr;
        logic [7:0]  ram_wdata;
        logic [3:0]  nibble;
        logic [11:0] x;
        logic [11:0] y;
        logic        beam;
        logic [31:0] rdata;
        logic        ready;
        logic        err;
    } vgc_state_s;

    vgc_state_s st_ff;
    vgc_state_s nxt_st;

    // One 4-bit ALU slice: group generate and propagate plus sum
    function automatic logic [5:0] vgc_alu_slice(input logic [3:0] a, input logic [3:0] b,
                                                 input logic [3:0] fn, input logic cin);
        logic [3:0] x;
        logic [3:0] y;
        logic [3:0] f;
        logic       c;
        logic       gg;
        logic       pp;
        x  = a | (b & {4{fn[0]}}) | (~b & {4{fn[1]}});
        y  = (a & ~b & {4{fn[2]}}) | (a & b & {4{fn[3]}});
        c  = cin;
        gg = 1'b0;
        pp = 1'b1;
        for (int i = 0; i < 4; i++) begin
            f[i] = (x[i] & ~y[i]) ^ c;
            c    = y[i] | (x[i] & c);
            gg   = y[i] | (x[i] & gg);
            pp   = pp & x[i];
        end
        return {gg, pp, f};
    endfunction

    // Preset decoder: from the zeroed count it yields the start that ends at max
    function automatic logic [11:0] vgc_line_decode(input logic [11:0] cnt,
                                                    input logic [11:0] len);
        return (cnt == vgc_pkg::LINE_RST) ? vgc_pkg::LINE_MAX - len : cnt;
    endfunction

    logic [3:0]  alu_fn;
    logic [11:0] acc_mux;
    logic [11:0] alu_b;
    logic [11:0] alu_result_bits;
    logic [2:0]  slice_g;
    logic [2:0]  slice_p;
    logic [3:0]  alu_c;
    logic [5:0]  slice_out [3];
    logic [3:0]  pc_carry;
    logic [11:0] pc_next;
    logic [7:0]  mem_cur;
    logic [7:0]  prog_data;
    logic [11:0] selected_data_bus;
    logic [11:0] prog_addr;
    logic [3:0]  data_low_nibble;
    logic [3:0]  ram_low_nib;
    logic        line_tick;
    logic        line_load_n;
    logic        counter_zeroing;
    logic        apb_wr;

    assign alu_fn = st_ff.ctrl[vgc_pkg::ALU_FN_LSB +: 4];

    // Both accumulators may address memory; one select serves all slices
    assign acc_mux = st_ff.ctrl[vgc_pkg::ACC_SEL_BIT] ? st_ff.pri : st_ff.sec;
    assign alu_b   = st_ff.ctrl[vgc_pkg::ALU_B_BIT] ? {4'h0, st_ff.dr} : acc_mux;

    // Look-ahead carry across the three slices
    assign alu_c[0] = st_ff.ctrl[vgc_pkg::CARRY_IN_BIT];
    assign alu_c[1] = slice_g[0] | (slice_p[0] & alu_c[0]);
    assign alu_c[2] = slice_g[1] | (slice_p[1] & slice_g[0])
                    | (slice_p[1] & slice_p[0] & alu_c[0]);
    assign alu_c[3] = slice_g[2] | (slice_p[2] & slice_g[1])
                    | (slice_p[2] & slice_p[1] & slice_g[0])
                    | (slice_p[2] & slice_p[1] & slice_p[0] & alu_c[0]);

    // Program counter slices carry into the next more significant one
    assign pc_carry[0] = st_ff.ctrl[vgc_pkg::PC_CNT_EN_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_slice
            assign slice_out[gi] = vgc_alu_slice(st_ff.pri[gi*4 +: 4], alu_b[gi*4 +: 4],
                                                 alu_fn, alu_c[gi]);
            assign alu_result_bits[gi*4 +: 4] = slice_out[gi][3:0];
            assign slice_g[gi] = slice_out[gi][5];
            assign slice_p[gi] = slice_out[gi][4];
            assign pc_next[gi*4 +: 4] = st_ff.pc[gi*4 +: 4] + {3'h0, pc_carry[gi]};
            assign pc_carry[gi+1] = pc_carry[gi] & (&st_ff.pc[gi*4 +: 4]);
        end
    endgenerate

    // Bank data mux; the delayed copy lets each bank take two cycles per word
    assign mem_cur   = st_ff.bank_odd ? odd_bank_data : even_bank_data;
    assign prog_data = (st_ff.ctrl[vgc_pkg::MUX_RST_BIT] | st_ff.ctrl[vgc_pkg::MUX_EVEN_BIT]
                        | ~st_ff.ctrl[vgc_pkg::MUX_ODD_BIT]) ? mem_cur : st_ff.mem_dly;

    assign prog_addr = st_ff.ctrl[vgc_pkg::ADDR_SEL_BIT] ? st_ff.pc : acc_mux;

    assign data_low_nibble = st_ff.dr[3:0];
    assign ram_low_nib = st_ff.ctrl[vgc_pkg::RAM_SEL_BIT]
                       ? (st_ff.ctrl[vgc_pkg::RAM_DLY_BIT] ? st_ff.dr_dly[3:0] : data_low_nibble)
                       : (st_ff.ctrl[vgc_pkg::RAM_NIB_BIT] ? ram_output_bits[7:4]
                                                           : ram_output_bits[3:0]);

    assign selected_data_bus = {4'h0, st_ff.ctrl[vgc_pkg::DATA_SEL_BIT] ? ram_output_bits
                                                                        : st_ff.dr};

    assign line_tick       = (st_ff.div_cnt == 16'(LINE_DIV - 1));
    assign counter_zeroing = apb_wr && (paddr == vgc_pkg::LINE_OFS);
    assign line_load_n     = ~(st_ff.line_run & st_ff.line_zeroed);
    assign apb_wr          = psel & penable & st_ff.ready & pwrite;

    always_comb begin
        nxt_st = st_ff;

        // Timer clock enable divider
        nxt_st.div_cnt = line_tick ? 16'h0000 : st_ff.div_cnt + 16'h0001;

        // Line length timer
        if (counter_zeroing) begin
            nxt_st.line_cnt    = vgc_pkg::LINE_RST;
            nxt_st.line_run    = 1'b1;
            nxt_st.line_zeroed = 1'b1;
            nxt_st.line_len    = pwdata[11:0];
        end else if (st_ff.line_run && line_tick) begin
            if (!line_load_n) begin
                nxt_st.line_cnt    = vgc_line_decode(st_ff.line_cnt, st_ff.line_len);
                nxt_st.line_zeroed = 1'b0;
            end else if (st_ff.line_cnt == vgc_pkg::LINE_MAX) begin
                nxt_st.line_run = 1'b0;
            end else begin
                nxt_st.line_cnt = st_ff.line_cnt + 12'h001;
            end
        end
        nxt_st.beam = nxt_st.line_run & ~nxt_st.line_zeroed;

        // Program address counter
        if (!st_ff.ctrl[vgc_pkg::PC_LOAD_N_BIT]) begin
            nxt_st.pc = st_ff.preset;
        end else begin
            nxt_st.pc = pc_next;
        end
        if (st_ff.ctrl[vgc_pkg::PRESET_LD_BIT]) begin
            nxt_st.preset = selected_data_bus;
        end

        // Memory path
        nxt_st.bank_addr = prog_addr[11:1];
        nxt_st.bank_odd  = prog_addr[0];
        nxt_st.mem_dly   = mem_cur;
        if (st_ff.ctrl[vgc_pkg::IR_LD_BIT]) begin
            nxt_st.ir = prog_data;
        end
        if (st_ff.ctrl[vgc_pkg::DR_LD_BIT]) begin
            nxt_st.dr     = prog_data;
            nxt_st.dr_dly = st_ff.dr;
        end
        nxt_st.nibble = st_ff.ctrl[vgc_pkg::IR_NIB_BIT] ? st_ff.ir[7:4] : st_ff.ir[3:0];

        // Working storage address and data
        if (st_ff.ctrl[vgc_pkg::PAGE_LD_BIT]) begin
            nxt_st.page = data_low_nibble;
        end
        nxt_st.ram_addr  = {st_ff.page, ram_low_nib};
        nxt_st.ram_wdata = acc_mux[7:0];

        // Accumulators
        unique case (st_ff.ctrl[vgc_pkg::PRI_MODE_LSB +: 2])
            vgc_pkg::ACC_HOLD: nxt_st.pri = st_ff.pri;
            vgc_pkg::ACC_SHR:  nxt_st.pri = {st_ff.sec[0], st_ff.pri[11:1]};
            vgc_pkg::ACC_SHL:  nxt_st.pri = {st_ff.pri[10:0], st_ff.sec[11]};
            vgc_pkg::ACC_LOAD: nxt_st.pri = alu_result_bits;
        endcase
        unique case (st_ff.ctrl[vgc_pkg::SEC_MODE_LSB +: 2])
            vgc_pkg::ACC_HOLD: nxt_st.sec = st_ff.sec;
            vgc_pkg::ACC_SHR:  nxt_st.sec = {st_ff.pri[0], st_ff.sec[11:1]};
            vgc_pkg::ACC_SHL:  nxt_st.sec = {st_ff.sec[10:0], st_ff.pri[11]};
            vgc_pkg::ACC_LOAD: nxt_st.sec = alu_result_bits;
        endcase
        nxt_st.carry_out = slice_g[2] | (slice_p[2] & alu_c[2]);

        // Coordinate registers for the DACs; X only in display mode
        if (st_ff.ctrl[vgc_pkg::COORD_LD_BIT]) begin
            if (st_ff.ctrl[vgc_pkg::DISP_BIT]) begin
                nxt_st.x = st_ff.pri;
            end
            nxt_st.y = st_ff.sec;
        end

        // One-shot strobes fall back after one cycle
        nxt_st.ctrl[vgc_pkg::PRESET_LD_BIT] = 1'b0;
        nxt_st.ctrl[vgc_pkg::PAGE_LD_BIT]   = 1'b0;
        nxt_st.ctrl[vgc_pkg::IR_LD_BIT]     = 1'b0;
        nxt_st.ctrl[vgc_pkg::DR_LD_BIT]     = 1'b0;
        nxt_st.ctrl[vgc_pkg::COORD_LD_BIT]  = 1'b0;

        // APB: answer one cycle after setup
        nxt_st.ready = psel & ~penable;
        // Error flag stands only alongside its ready pulse
        nxt_st.err   = 1'b0;
        if (psel && !penable) begin
            nxt_st.err   = 1'b0;
            nxt_st.rdata = 32'h0000_0000;
            unique case (paddr)
                vgc_pkg::CTRL_OFS:  nxt_st.rdata = {4'h0, st_ff.ctrl};
                vgc_pkg::LINE_OFS:  nxt_st.rdata = {4'h0, st_ff.line_cnt, 4'h0, st_ff.line_len};
                vgc_pkg::STAT_OFS:  nxt_st.rdata = {5'h00, st_ff.carry_out, st_ff.beam,
                                                    st_ff.line_run, st_ff.preset, st_ff.pc};
                vgc_pkg::ACC_OFS:   nxt_st.rdata = {4'h0, st_ff.sec, 4'h0, st_ff.pri};
                vgc_pkg::DATA_OFS:  nxt_st.rdata = {8'h00, st_ff.page, 4'h0, st_ff.ir,
                                                    st_ff.dr};
                vgc_pkg::COORD_OFS: nxt_st.rdata = {4'h0, st_ff.y, 4'h0, st_ff.x};
                default:            nxt_st.err = 1'b1;
            endcase
        end
        if (apb_wr && paddr == vgc_pkg::CTRL_OFS) begin
            nxt_st.ctrl = pwdata[vgc_pkg::CTRL_W-1:0];
        end
        if (apb_wr && paddr == vgc_pkg::ACC_OFS) begin
            nxt_st.pri = pwdata[11:0];
            nxt_st.sec = pwdata[27:16];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= '0;
            st_ff.ctrl <= vgc_pkg::CTRL_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata                 = st_ff.rdata;
    assign pready                 = st_ff.ready;
    assign pslverr                = st_ff.err;
    assign bank_addr              = st_ff.bank_addr;
    assign bank_odd               = st_ff.bank_odd;
    assign ram_address_bits       = st_ff.ram_addr;
    assign ram_write_data         = st_ff.ram_wdata;
    assign instruction_data_lines = st_ff.nibble;
    assign x_coord                = st_ff.x;
    assign y_coord                = st_ff.y;
    assign beam_on                = st_ff.beam;

endmodule

/* File: tb/vgc_datapath_assertions.sv */
`timescale 1ns/1ps
module vgc_datapath_assertions #(
    parameter int LINE_DIV = 1
) (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Datapath outputs
    input wire logic [10:0] bank_addr,
    input wire logic        bank_odd,
    input wire logic        beam_on
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        wr_hit;
    logic        line_wr;
    logic        mapped;
    logic [11:0] pa;
    logic [2:0]  ctl_ff;
    logic [11:0] len_ff;
    logic [15:0] hi_ff;
    logic [1:0]  run_ff;
    assign wr_hit  = psel && penable && pready && pwrite;
    assign line_wr = wr_hit && paddr == vgc_pkg::LINE_OFS;
    assign mapped  = paddr <= vgc_pkg::COORD_OFS && paddr[1:0] == 2'h0;
    assign pa      = {bank_addr, bank_odd};
    // Shadow of counter controls and line length, taken from bus writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_ff <= 3'h1;
            len_ff <= 12'h000;
            hi_ff  <= 16'h0;
            run_ff <= 2'h0;
        end else begin
            if (wr_hit && paddr == vgc_pkg::CTRL_OFS) ctl_ff <= pwdata[2:0];
            if (line_wr) len_ff <= pwdata[11:0];
            hi_ff  <= (beam_on && !line_wr) ? hi_ff + 16'h1 : 16'h0;
            run_ff <= (ctl_ff != 3'h7) ? 2'h0 : (run_ff == 2'h3) ? run_ff : run_ff + 2'h1;
        end
    end
    AST_RDY_PULSE: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    AST_RDY_SETUP: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    AST_RDY_ACC: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error flag does not match address map");
    AST_ERR_DATA: assert property (pslverr |-> prdata == 32'h0)
        else $error("read data not zero on error");
    AST_RST_IDLE: assert property ($rose(presetn) |-> !beam_on && !pready)
        else $error("outputs active right after reset");
    AST_BEAM_START: assert property (line_wr && pwdata[11:0] != 12'h0 |-> ##[1:4] beam_on)
        else $error("beam not started after length write");
    AST_BEAM_MAX: assert property (beam_on |-> hi_ff <= (32'(len_ff) + 3) * LINE_DIV)
        else $error("beam held past maximum count");
    AST_BEAM_LEN: assert property ($fell(beam_on) |-> hi_ff >= 32'(len_ff) * LINE_DIV)
        else $error("beam dropped before interval ended");
    AST_PC_COUNT: assert property (run_ff == 2'h3 && ctl_ff == 3'h7 |-> pa == $past(pa) + 12'h1)
        else $error("program address did not step by one");
    cover property (pslverr);
    cover property ($fell(beam_on));
    cover property (run_ff == 2'h3);
endmodule

bind vgc_datapath vgc_datapath_assertions #(.LINE_DIV(LINE_DIV)) i_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bank_addr, .bank_odd, .beam_on
);

/* File: tb/vgc_mem_model.sv */
`timescale 1ns/1ps
module vgc_mem_model (
    // Bank address
    input wire logic [10:0] bank_addr,
    // Bank and RAM data
    output logic     [7:0]  even_bank_data,
    output logic     [7:0]  odd_bank_data,
    output logic     [7:0]  ram_output_bits
);
    // Even words in one bank, odd words in the other, tagged by the low bit
    assign even_bank_data  = {bank_addr[6:0], 1'b0};
    assign odd_bank_data   = {bank_addr[6:0], 1'b1};
    // Fixed RAM word keeps RAM-sourced addresses predictable
    assign ram_output_bits = 8'h5a;
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [10:0] bank_addr;
    logic        bank_odd;
    logic [7:0]  even_bank_data;
    logic [7:0]  odd_bank_data;
    logic [7:0]  ram_address_bits;
    logic [7:0]  ram_write_data;
    logic [7:0]  ram_output_bits;
    logic [3:0]  instruction_data_lines;
    logic [11:0] x_coord;
    logic [11:0] y_coord;
    logic        beam_on;
    logic [31:0] rv;
    logic        ev;
    int          err_count = 0;
    int          comparisons = 0;

    vgc_datapath #(.LINE_DIV(1)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .bank_addr, .bank_odd, .even_bank_data, .odd_bank_data,
        .ram_address_bits, .ram_write_data, .ram_output_bits,
        .instruction_data_lines, .x_coord, .y_coord, .beam_on
    );
    vgc_mem_model i_mem (.bank_addr, .even_bank_data, .odd_bank_data, .ram_output_bits);

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            err_count++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_regs();
        apb(1'b0, vgc_pkg::CTRL_OFS, 32'h0, rv, ev);
        chk("ctrl reset", rv, 32'(vgc_pkg::CTRL_RST));
        chk("beam idle", beam_on, 1'b0);
        apb(1'b1, vgc_pkg::DATA_OFS, 32'hffffffff, rv, ev);
        apb(1'b0, vgc_pkg::DATA_OFS, 32'h0, rv, ev);
        chk("data read only", rv, 32'h0);
        apb(1'b0, 8'h18, 32'h0, rv, ev);
        chk("unmapped error", ev, 1'b1);
        chk("unmapped data", rv, 32'h0);
    endtask

    task automatic t_line();
        logic [11:0] lens [3] = '{12'h001, 12'h014, 12'h0c8};
        int c;
        foreach (lens[i]) begin
            apb(1'b1, vgc_pkg::LINE_OFS, {20'h0, lens[i]}, rv, ev);
            c = 0;
            repeat (lens[i] + 16) begin
                @(posedge pclk);
                if (beam_on === 1'b1) c++;
            end
            chk("beam length", 32'(c >= lens[i] && c <= lens[i] + 2), 32'h1);
            chk("beam off at max", beam_on, 1'b0);
            apb(1'b0, vgc_pkg::LINE_OFS, 32'h0, rv, ev);
            chk("line length", rv[11:0], lens[i]);
        end
    endtask

    task automatic t_alu();
        logic [11:0] p [3] = '{12'h0ff, 12'hfff, 12'h0a5};
        // Secondary loads primary plus primary, plus carry in after the first pass, so it settles at once
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, vgc_pkg::ACC_OFS, {20'h0, p[i]}, rv, ev);
            apb(1'b1, vgc_pkg::CTRL_OFS, i > 0 ? 32'h19909 : 32'h18909, rv, ev);
            apb(1'b0, vgc_pkg::STAT_OFS, 32'h0, rv, ev);
            chk("alu carry", rv[26], 32'(p[i] + p[i] + (i > 0) > 32'hfff));
            apb(1'b1, vgc_pkg::CTRL_OFS, 32'h1, rv, ev);
            apb(1'b0, vgc_pkg::ACC_OFS, 32'h0, rv, ev);
            chk("alu sum", rv[27:16], 12'(p[i] + p[i] + (i > 0)));
            chk("primary kept", rv[11:0], p[i]);
        end
    endtask

    task automatic t_mux();
        apb(1'b1, vgc_pkg::ACC_OFS, 32'h04560123, rv, ev);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, vgc_pkg::CTRL_OFS, 32'h1 | (s << vgc_pkg::ACC_SEL_BIT), rv, ev);
            repeat (3) @(posedge pclk);
            chk("alt address", {bank_addr, bank_odd}, s ? 12'h123 : 12'h456);
            chk("ram write data", ram_write_data, s ? 8'h23 : 8'h56);
        end
    endtask

    task automatic t_coord();
        apb(1'b1, vgc_pkg::ACC_OFS, 32'h0def0abc, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h3000001, rv, ev);
        repeat (3) @(posedge pclk);
        chk("x coordinate", x_coord, 12'habc);
        chk("y coordinate", y_coord, 12'hdef);
    endtask

    task automatic t_pc();
        int d;
        // Preset from RAM output through the data selector, then hold load
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h20084, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h4, rv, ev);
        repeat (3) @(posedge pclk);
        chk("preset loaded", {bank_addr, bank_odd}, 12'h05a);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h7, rv, ev);
        repeat (40) @(posedge pclk);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h5, rv, ev);
        repeat (3) @(posedge pclk);
        apb(1'b0, vgc_pkg::STAT_OFS, 32'h0, rv, ev);
        d = rv[11:0] - 12'h05a;
        chk("counter steps", 32'(d >= 40 && d <= 48), 32'h1);
        chk("counter drives bus", {bank_addr, bank_odd}, rv[11:0]);
        chk("preset value", rv[23:12], 12'h05a);
    endtask

    task automatic t_ram();
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, vgc_pkg::CTRL_OFS, 32'h1 | (h << vgc_pkg::RAM_NIB_BIT), rv, ev);
            repeat (3) @(posedge pclk);
            chk("ram address", ram_address_bits, h ? 8'h05 : 8'h0a);
        end
    endtask

    task automatic t_word();
        // Primary 0x0a5 addresses the odd bank, whose model returns the address
        apb(1'b1, vgc_pkg::ACC_OFS, 32'h000000a5, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h9, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h180009, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h40009, rv, ev);
        apb(1'b1, vgc_pkg::CTRL_OFS, 32'h4000019, rv, ev);
        repeat (3) @(posedge pclk);
        chk("instruction nibble", instruction_data_lines, 4'ha);
        chk("ram page address", ram_address_bits, 8'h55);
        apb(1'b0, vgc_pkg::DATA_OFS, 32'h0, rv, ev);
        chk("data word", rv, 32'h0050a5a5);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_line();
        t_alu();
        t_mux();
        t_coord();
        t_pc();
        t_ram();
        t_word();
        print_verdict();
    end

    // The whole sequence needs about five hundred cycles
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        print_verdict();
    end
endmodule
